// *** inc/dpga_pkg.sv ***
// Constants, types and register map of the dual port grant arbiter
package dpga_pkg;
    // System clock and derived internal timebases
    localparam int unsigned CLK_HZ      = 25000000;
    localparam int unsigned OSC_HZ      = 30000;
    localparam int unsigned TMR_HZ      = 10000;
    localparam int unsigned OSC_DIV     = CLK_HZ / OSC_HZ;   // Rounds down
    localparam int unsigned TMR_DIV     = OSC_HZ / TMR_HZ;
    localparam int unsigned WARMUP_MS   = 5;
    localparam int unsigned WARMUP_CYC  = WARMUP_MS * (CLK_HZ / 1000);
    localparam logic [9:0]  OSC_LAST    = 10'(OSC_DIV - 1);
    localparam logic [1:0]  TMR_LAST    = 2'(TMR_DIV - 1);
    // Oscillator ticks spent sensing and driving the presence pulse
    localparam logic [2:0]  SENSE_TICKS = 3'h4;
    localparam logic [2:0]  PRES_TICKS  = 3'h4;

    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG  = 8'h00;
    localparam logic [7:0] OFS_TIMEOUT = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_GPIO_OUT = 8'h0C;
    localparam logic [7:0] OFS_GPIO_IN = 8'h10;
    localparam logic [7:0] OFS_ID_LO   = 8'h14;
    localparam logic [7:0] OFS_ID_HI   = 8'h18;

    // Field positions
    localparam int CFG_SEL   = 0;
    localparam int CFG_QUIET = 1;
    localparam int CFG_PASS  = 2;
    localparam int CFG_HOLD  = 3;
    localparam int ST_GRANT_B = 0;
    localparam int ST_PASS   = 1;
    localparam int ST_HV     = 2;
    localparam int ST_WARM   = 3;
    localparam int ST_LINE_A = 4;
    localparam int ST_LINE_B = 5;

    // Reset values
    localparam logic [3:0] CONFIG_RST  = 4'h0;
    localparam logic [7:0] TIMEOUT_RST = 8'h0A;
    localparam logic [2:0] GPIO_RST    = 3'h0;

    // Arbitration states
    typedef enum logic [2:0] {
        S_POR, S_SENSE, S_A_TOKEN, S_B_TOKEN, S_PASS, S_QUIET, S_HOLD
    } dpga_state_t;

    // Mode configuration bits
    typedef struct packed {
        logic hold_high_bit;
        logic passthru_mode_bit;
        logic quiet_mode_bit;
        logic sel_bit;
    } dpga_cfg_t;

    // Conditioned pin levels
    typedef struct packed {
        logic [2:0] gpio;
        logic       hv;
        logic       port_b;
        logic       port_a;
    } dpga_lines_t;
endpackage

// *** core/dpga_sync.sv ***
// Three stage input conditioner with agreement filter
`timescale 1ns/100ps
module dpga_sync #(
    parameter int W = 1
) (
    input  wire logic         hclk,     // System clock
    input  wire logic         hresetn,  // Async reset, active low
    input  wire logic [W-1:0] async_in, // Pin levels
    output logic      [W-1:0] sync_out  // Filtered levels
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;

    // First stage feeds only the second; output moves once two later stages agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_ff    <= '0;
            s2_ff    <= '0;
            s3_ff    <= '0;
            sync_out <= '0;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < W; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    sync_out[i] <= s3_ff[i];
                end
            end
        end
    end
endmodule // dpga_sync

// *** core/dpga_arbiter.sv ***
// Grant arbiter of the two port bridge with AHB-Lite register slave
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
//
// Overview of operation
// RQ1 - Grant pin low for A, high for B
// RQ2 - Grant pin toggles as clock in pass-through
// RQ3 - Charger pin is gpio when select bit set
// RQ4 - Charger pin pulls low while A above 4V
// RQ5 - Unique 64-bit identifier selects one device
// RQ6 - Granted controller sets config, gpio, timeout
// RQ7 - Pass-through timer restarts on any falling edge
// RQ8 - Ignore lines during warm-up after power-up only
// RQ9 - State changes only on internal oscillator ticks
// RQ10 - Timer counts on 10kHz divided tick
// RQ11 - High voltage on A grants B, enables charging; the code does both only while the select bit is clear
// RQ12 - Presence pulse on B when A hands over
// RQ13 - No high voltage: branch on mode bits
// RQ14 - No modes and A high grants A
// RQ15 - A gets no presence pulse on grant
// RQ16 - A keeps grant until line times out low
// RQ17 - A pulldown on except sense, pass, hold-high
// RQ18 - B holds grant until A high, then resense
// RQ19 - A fall restarts timer; expiry low grants B
// RQ20 - A controller keeps line low under B grant
// RQ21 - A high again acts only at timer expiry
// RQ22 - Controllers wait 5 ms after power-on
// RQ23 - Line inputs synchronised before edges and decisions
module dpga_arbiter
    import dpga_pkg::*;
#(
    parameter int unsigned WARMUP_CYCLES = WARMUP_CYC,     // Power-up warm-up length
    parameter logic [63:0] UNIQUE_ID     = 64'h0123456789ABCDEF // Arbitrary value
) (
    input  wire logic        hclk,                 // Clock, 25 MHz
    input  wire logic        hresetn,              // Async reset, active low
    input  wire logic        hsel,                 // Slave select
    input  wire logic [31:0] haddr,                // Byte address
    input  wire logic [1:0]  htrans,               // Transfer type
    input  wire logic        hwrite,               // Write when high
    input  wire logic [2:0]  hsize,                // Transfer size
    input  wire logic [31:0] hwdata,               // Write data
    input  wire logic        hready,               // Bus ready
    output logic      [31:0] hrdata,               // Read data
    output logic             hreadyout,            // Slave ready
    output logic             hresp,                // Always OKAY
    input  wire logic        port_a_line_in,       // Port A line level
    output logic             port_a_pulldown_en,   // Port A weak pulldown on
    output logic             pass_switch_en,       // Pass-through switch on
    input  wire logic        port_b_line_in,       // Port B line level
    output logic             port_b_line_out,      // Port B drive level
    output logic             port_b_line_oe,       // Port B pulled low
    input  wire logic        hv_cmp_in,            // Port A above 4V
    output logic             grant_pin_oe,         // Grant pin pulled low
    input  wire logic        charger_ctrl_gpio_c_pin_in,  // Charger pin level
    output logic             charger_ctrl_gpio_c_pin_out, // Charger pin drive level
    output logic             charger_ctrl_gpio_c_pin_oe,  // Charger pin pulled low
    input  wire logic        gpio_a_pin_in,        // Gpio A level
    output logic             gpio_a_pin_out,       // Gpio A drive level
    output logic             gpio_a_pin_oe,        // Gpio A pulled low
    input  wire logic        gpio_b_pin_in,        // Gpio B level
    output logic             gpio_b_pin_out,       // Gpio B drive level
    output logic             gpio_b_pin_oe         // Gpio B pulled low
);
    dpga_lines_t lines;
    dpga_lines_t lines_raw;
    dpga_state_t state_ff;
    dpga_cfg_t   cfg_ff;
    logic [7:0]  timeout_ff;
    logic [2:0]  gpio_out_ff;
    logic [9:0]  osc_cnt_ff;
    logic        osc_tick_ff;
    logic [1:0]  tmr_div_ff;
    logic [7:0]  tmr_cnt_ff;
    logic        tmr_run_ff;
    logic        tmr_expired;
    logic        tmr_restart;
    logic [31:0] warm_cnt_ff;
    logic        warm_done_ff;
    logic        a_prev_ff;
    logic        b_prev_ff;
    logic        fall_a_ff;
    logic        fall_b_ff;
    logic [2:0]  sense_cnt_ff;
    logic [2:0]  pres_cnt_ff;
    logic        pres_start;
    logic        grant_clk_ff;
    logic        wr_pend_ff;
    logic [7:0]  wr_addr_ff;
    logic        addr_ok;
    logic [31:0] rd_mux;

    assign lines_raw = '{gpio: {charger_ctrl_gpio_c_pin_in, gpio_b_pin_in, gpio_a_pin_in},
                         hv: hv_cmp_in, port_b: port_b_line_in, port_a: port_a_line_in};

    // All pin levels conditioned before any edge or decision
    dpga_sync #(.W(6)) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (lines_raw),     // RQ23
        .sync_out (lines)
    );

    // Internal oscillator tick derived from the system clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_cnt_ff  <= '0;
            osc_tick_ff <= 1'b0;
        end else begin
            osc_tick_ff <= (osc_cnt_ff == OSC_LAST);
            osc_cnt_ff  <= (osc_cnt_ff == OSC_LAST) ? 10'h000 : osc_cnt_ff + 10'h001;
        end
    end

    // Warm-up runs once after reset; later state changes never restart it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            warm_cnt_ff  <= '0;
            warm_done_ff <= 1'b0;
        end else if (!warm_done_ff) begin
            warm_cnt_ff  <= warm_cnt_ff + 32'h00000001;
            warm_done_ff <= (warm_cnt_ff >= WARMUP_CYCLES - 1); // RQ8
        end
    end

    // Falling edges held until the next oscillator tick; a new edge beats the clear.
    // Previous levels reset low like the conditioner, so no false fall after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_prev_ff <= 1'b0;
            b_prev_ff <= 1'b0;
            fall_a_ff <= 1'b0;
            fall_b_ff <= 1'b0;
        end else begin
            a_prev_ff <= lines.port_a;
            b_prev_ff <= lines.port_b;
            fall_a_ff <= (a_prev_ff & ~lines.port_a) | (fall_a_ff & ~osc_tick_ff);
            fall_b_ff <= (b_prev_ff & ~lines.port_b) | (fall_b_ff & ~osc_tick_ff);
        end
    end

    // Timer restarts on port A falls, or on either port in pass-through
    assign tmr_restart = osc_tick_ff & (fall_a_ff | (state_ff == S_PASS & fall_b_ff)); // RQ7 RQ19
    assign tmr_expired = tmr_run_ff & (tmr_cnt_ff >= timeout_ff);

    // Inactivity timer counted in 10kHz ticks, three oscillator ticks each
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmr_div_ff <= '0;
            tmr_cnt_ff <= '0;
            tmr_run_ff <= 1'b0;
        end else if (osc_tick_ff) begin
            tmr_div_ff <= (tmr_div_ff == TMR_LAST) ? 2'h0 : tmr_div_ff + 2'h1; // RQ10
            if (tmr_restart) begin
                tmr_cnt_ff <= 8'h00;
                tmr_run_ff <= 1'b1;
            end else if (tmr_expired) begin
                tmr_run_ff <= 1'b0;
            end else if (tmr_div_ff == TMR_LAST && tmr_run_ff) begin
                tmr_cnt_ff <= tmr_cnt_ff + 8'h01;
            end
        end
    end

    // Hand-over from A to B starts the presence pulse on port B
    assign pres_start = osc_tick_ff & ~tmr_restart & tmr_expired & ~lines.port_a
                        & (state_ff == S_A_TOKEN | state_ff == S_HOLD);

    // Arbitration state machine, advanced only on oscillator ticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff     <= S_POR;
            sense_cnt_ff <= '0;
        end else if (osc_tick_ff) begin // RQ9
            case (state_ff)
                S_POR: begin
                    if (warm_done_ff) begin // RQ8
                        state_ff     <= S_SENSE;
                        sense_cnt_ff <= '0;
                    end
                end
                S_SENSE: begin
                    // Comparator given several ticks with the pulldown off
                    sense_cnt_ff <= sense_cnt_ff + 3'h1;
                    if (sense_cnt_ff == SENSE_TICKS) begin
                        if (!cfg_ff.sel_bit && lines.hv) begin
                            state_ff <= S_B_TOKEN; // RQ11
                        end else if (cfg_ff.quiet_mode_bit) begin
                            state_ff <= S_QUIET; // RQ13
                        end else if (cfg_ff.passthru_mode_bit) begin
                            state_ff <= S_PASS; // RQ13
                        end else if (cfg_ff.hold_high_bit) begin
                            state_ff <= S_HOLD; // RQ13
                        end else if (lines.port_a) begin
                            state_ff <= S_A_TOKEN; // RQ14
                        end else begin
                            state_ff <= S_B_TOKEN; // RQ18
                        end
                    end
                end
                S_A_TOKEN, S_HOLD: begin
                    // Grant given up at timer expiry; line still low hands over to B, else resense
                    if (!tmr_restart && tmr_expired) begin // RQ16 RQ19 RQ21
                        state_ff     <= lines.port_a ? S_SENSE : S_B_TOKEN;
                        sense_cnt_ff <= '0;
                    end
                end
                S_B_TOKEN: begin
                    if (lines.port_a) begin // RQ18
                        state_ff     <= S_SENSE;
                        sense_cnt_ff <= '0;
                    end
                end
                S_PASS: begin
                    if (!tmr_restart && tmr_expired) begin // RQ7
                        state_ff     <= S_SENSE;
                        sense_cnt_ff <= '0;
                    end
                end
                S_QUIET: begin
                    if (!cfg_ff.quiet_mode_bit) begin
                        state_ff     <= S_SENSE;
                        sense_cnt_ff <= '0;
                    end
                end
                default: state_ff <= S_POR;
            endcase
        end
    end

    // Presence pulse length counted in oscillator ticks; port A never gets one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pres_cnt_ff    <= '0;
            port_b_line_oe <= 1'b0;
        end else begin
            if (pres_start) begin
                pres_cnt_ff <= PRES_TICKS; // RQ12 RQ15
            end else if (osc_tick_ff && pres_cnt_ff != 3'h0) begin
                pres_cnt_ff <= pres_cnt_ff - 3'h1;
            end
            port_b_line_oe <= (pres_cnt_ff != 3'h0);
        end
    end

    // Grant pin, pulldown and pass switch from the current state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            grant_clk_ff       <= 1'b0;
            grant_pin_oe       <= 1'b0;
            port_a_pulldown_en <= 1'b0;
            pass_switch_en     <= 1'b0;
        end else begin
            if (osc_tick_ff) begin
                grant_clk_ff <= ~grant_clk_ff;
            end
            case (state_ff)
                S_A_TOKEN, S_HOLD: grant_pin_oe <= 1'b1; // RQ1
                S_PASS:            grant_pin_oe <= grant_clk_ff; // RQ2
                default:           grant_pin_oe <= 1'b0; // RQ1
            endcase
            port_a_pulldown_en <= !(state_ff == S_SENSE || state_ff == S_PASS
                                    || state_ff == S_HOLD); // RQ17
            pass_switch_en     <= (state_ff == S_PASS);
        end
    end

    // Charger pin follows the comparator by default, else acts as gpio C
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            charger_ctrl_gpio_c_pin_oe <= 1'b0;
            gpio_a_pin_oe              <= 1'b0;
            gpio_b_pin_oe              <= 1'b0;
        end else begin
            charger_ctrl_gpio_c_pin_oe <= cfg_ff.sel_bit ? gpio_out_ff[2] : lines.hv; // RQ3 RQ4
            gpio_a_pin_oe              <= gpio_out_ff[0];
            gpio_b_pin_oe              <= gpio_out_ff[1];
        end
    end

    // Open-drain drive levels are always low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_b_line_out             <= 1'b0;
            charger_ctrl_gpio_c_pin_out <= 1'b0;
            gpio_a_pin_out              <= 1'b0;
            gpio_b_pin_out              <= 1'b0;
        end else begin
            port_b_line_out             <= 1'b0;
            charger_ctrl_gpio_c_pin_out <= 1'b0;
            gpio_a_pin_out              <= 1'b0;
            gpio_b_pin_out              <= 1'b0;
        end
    end

    // Bus slave: zero wait states, address captured for the write data phase
    assign addr_ok = hsel & hready & htrans[1];
    always_comb begin
        case (haddr[7:0])
            OFS_CONFIG:   rd_mux = {28'h0000000, cfg_ff};
            OFS_TIMEOUT:  rd_mux = {24'h000000, timeout_ff};
            OFS_STATUS:   rd_mux = {26'h0000000, lines.port_b, lines.port_a, warm_done_ff,
                                    lines.hv, (state_ff == S_PASS),
                                    !(state_ff == S_A_TOKEN || state_ff == S_HOLD)};
            OFS_GPIO_OUT: rd_mux = {29'h0000000, gpio_out_ff};
            OFS_GPIO_IN:  rd_mux = {29'h0000000, lines.gpio};
            OFS_ID_LO:    rd_mux = UNIQUE_ID[31:0]; // RQ5
            OFS_ID_HI:    rd_mux = UNIQUE_ID[63:32]; // RQ5
            default:      rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
            hrdata     <= '0;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else begin
            wr_pend_ff <= addr_ok & hwrite;
            wr_addr_ff <= haddr[7:0];
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            if (addr_ok && !hwrite) begin
                hrdata <= (haddr[31:8] == 24'h000000) ? rd_mux : 32'h00000000;
            end
        end
    end

    // Software-written settings steer the arbiter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ff      <= CONFIG_RST;
            timeout_ff  <= TIMEOUT_RST;
            gpio_out_ff <= GPIO_RST;
        end else if (wr_pend_ff) begin
            case (wr_addr_ff)
                OFS_CONFIG:   cfg_ff      <= hwdata[3:0]; // RQ6
                OFS_TIMEOUT:  timeout_ff  <= hwdata[7:0]; // RQ6
                OFS_GPIO_OUT: gpio_out_ff <= hwdata[2:0]; // RQ6
                default:      cfg_ff      <= cfg_ff;
            endcase
        end
    end
endmodule // dpga_arbiter

// *** tb/dpga_monitor.sv ***
// Port checker of the dual port grant arbiter
`timescale 1ns/100ps
module dpga_monitor
    import dpga_pkg::*;
#(
    parameter int unsigned WARMUP_CYCLES = WARMUP_CYC // Warm-up length
) (
    input wire logic hclk,                        // Clock
    input wire logic hresetn,                     // Reset, active low
    input wire logic hreadyout,                   // Slave ready
    input wire logic hresp,                       // Response
    input wire logic grant_pin_oe,                // Grant pin low
    input wire logic pass_switch_en,              // Pass-through on
    input wire logic port_a_pulldown_en,          // A pulldown on
    input wire logic port_b_line_out,             // B drive level
    input wire logic port_b_line_oe,              // B pulled low
    input wire logic charger_ctrl_gpio_c_pin_out  // Charger drive level
);
    logic [15:0] pres_cnt_ff; // Presence pulse length so far
    logic [31:0] warm_cnt_ff; // Cycles since reset release

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Pulse length is counted so its width can be judged at the falling edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) pres_cnt_ff <= 16'h0000;
        else pres_cnt_ff <= port_b_line_oe ? pres_cnt_ff + 16'h0001 : 16'h0000;
    end

    // Saturating, so a long run cannot wrap back into the warm-up window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) warm_cnt_ff <= 32'h0;
        else if (warm_cnt_ff < WARMUP_CYCLES) warm_cnt_ff <= warm_cnt_ff + 32'h1;
    end

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("Bus answer not ready or not okay");
    a_open_drain: assert property (!port_b_line_out && !charger_ctrl_gpio_c_pin_out)
        else $error("Open drain pin driven high");
    a_grant_tick: assert property ($changed(grant_pin_oe) |=> $stable(grant_pin_oe)[*8])
        else $error("Grant pin changed off the oscillator pace");
    a_pass_clock: assert property (pass_switch_en |->
        ##[1:900] ($changed(grant_pin_oe) || !pass_switch_en))
        else $error("Grant pin not toggling in pass-through");
    a_pass_pulldown: assert property (pass_switch_en && $past(pass_switch_en)
        |-> !port_a_pulldown_en) else $error("A pulldown on in pass-through");
    a_pres_side: assert property (port_b_line_oe |->
        !grant_pin_oe && port_a_pulldown_en) else $error("Presence pulse while A granted");
    a_pres_width: assert property ($fell(port_b_line_oe) |->
        pres_cnt_ff == 16'(PRES_TICKS) * (16'(OSC_LAST) + 16'h0001))
        else $error("Presence pulse width wrong");
    a_warm_idle: assert property (warm_cnt_ff < WARMUP_CYCLES |->
        !port_b_line_oe && !pass_switch_en) else $error("Line activity during warm-up");
endmodule // dpga_monitor

bind dpga_arbiter dpga_monitor #(.WARMUP_CYCLES(WARMUP_CYCLES)) u_dpga_monitor (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .grant_pin_oe(grant_pin_oe), .pass_switch_en(pass_switch_en),
    .port_a_pulldown_en(port_a_pulldown_en), .port_b_line_out(port_b_line_out),
    .port_b_line_oe(port_b_line_oe),
    .charger_ctrl_gpio_c_pin_out(charger_ctrl_gpio_c_pin_out));

// *** tb/dpga_partner.sv ***
// Two line controllers facing the arbiter, with pull-ups on both lines
`timescale 1ns/100ps
module dpga_partner (
    input  wire logic [1:0] a_mode,  // 0 idle, 1 low, 2 open, 3 high voltage
    input  wire logic       b_low,   // B controller pulls low
    input  wire logic       a_pd_en, // Device A pulldown
    input  wire logic       b_oe,    // Device pulls B low
    output logic            line_a,  // Port A level
    output logic            line_b,  // Port B level
    output logic            hv       // Port A above 4V
);
    // Open A line falls only through the weak pulldown; a held low keeps B granted
    assign line_a = !(a_mode == 2'h1 || (a_mode == 2'h2 && a_pd_en));
    // Pull-up on B wins unless a party pulls low
    assign line_b = !(b_low || b_oe);
    assign hv = a_mode == 2'h3;
endmodule // dpga_partner

// *** tb/dual_port_grant_arbiter_bench.sv ***
// Self-checking bench of the dual port grant arbiter
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module dual_port_grant_arbiter_bench import dpga_pkg::*;;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, seen;
    logic [1:0]  htrans, a_mode;
    logic [31:0] haddr, hwdata, hrdata, rd_data;
    logic        b_low, line_a, line_b, hv, pd_en, pass_en, b_oe, b_out, grant;
    logic        chg_out, chg_oe, ga_out, ga_oe, gb_out, gb_oe;
    logic [3:0]  obs;
    int          fails, checked;

    assign obs = {chg_oe, b_oe, pass_en, grant};

    dpga_partner u_dpga_partner (.a_mode(a_mode), .b_low(b_low), .a_pd_en(pd_en),
        .b_oe(b_oe), .line_a(line_a), .line_b(line_b), .hv(hv));
    // Shortened warm-up keeps the run brief
    dpga_arbiter #(.WARMUP_CYCLES(2000)) u_dpga_arbiter (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .port_a_line_in(line_a), .port_a_pulldown_en(pd_en), .pass_switch_en(pass_en),
        .port_b_line_in(line_b), .port_b_line_out(b_out), .port_b_line_oe(b_oe),
        .hv_cmp_in(hv), .grant_pin_oe(grant), .charger_ctrl_gpio_c_pin_in(!chg_oe),
        .charger_ctrl_gpio_c_pin_out(chg_out), .charger_ctrl_gpio_c_pin_oe(chg_oe),
        .gpio_a_pin_in(!ga_oe), .gpio_a_pin_out(ga_out), .gpio_a_pin_oe(ga_oe),
        .gpio_b_pin_in(!gb_oe), .gpio_b_pin_out(gb_out), .gpio_b_pin_oe(gb_oe));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = !hclk;
    end

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Samples at the falling edge so the rising edge updates have landed
    task automatic wait_on(input int i, input logic v);
        int n;
        for (n = 0; obs[i] !== v; n++) begin
            if (n > 20000) begin
                fails++;
                give_verdict();
            end
            @(negedge hclk);
        end
    endtask

    task automatic ahb_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            if (++n > 50) begin
                fails++;
                give_verdict();
            end
            @(posedge hclk);
        end
    endtask

    // One single word transfer; read data taken at the closing edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        ahb_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        ahb_rdy();
        rd_data = hrdata;
    endtask

    task automatic a_drive(input logic [1:0] m, input int cyc);
        @(posedge hclk);
        a_mode <= 2'h1;
        repeat (cyc) @(posedge hclk);
        a_mode <= m;
    endtask

    task automatic t_regs;
        ahb(1'b0, OFS_TIMEOUT, 32'h0);
        `CHK("timeout reset", {24'h000000, TIMEOUT_RST}, rd_data)
        ahb(1'b0, 8'hFC, 32'h0);
        `CHK("unmapped", 32'h0, rd_data)
        ahb(1'b1, OFS_TIMEOUT, 32'h2);
        ahb(1'b0, OFS_TIMEOUT, 32'h0);
        `CHK("timeout", 32'h2, rd_data)
        ahb(1'b1, OFS_GPIO_OUT, 32'h7);
        repeat (2) @(negedge hclk);
        `CHK("gpio oe", 3'h3, {chg_oe, gb_oe, ga_oe})
        ahb(1'b1, OFS_CONFIG, 32'h1);
        repeat (8) @(negedge hclk);
        `CHK("gpio c oe", 1'b1, chg_oe)
        ahb(1'b0, OFS_GPIO_IN, 32'h0);
        `CHK("gpio in", 32'h0, rd_data)
        ahb(1'b1, OFS_CONFIG, 32'h0);
        ahb(1'b1, OFS_GPIO_OUT, 32'h0);
    endtask

    task automatic t_grant_a;
        wait_on(0, 1'b1);
        `CHK("presence on A grant", 1'b0, b_oe)
        `CHK("A pulldown", 1'b1, pd_en)
        ahb(1'b0, OFS_STATUS, 32'h0);
        `CHK("status", 6'h38, rd_data[5:0])
    endtask

    // A short low returned high before expiry must not hand over
    task automatic t_short;
        seen = 1'b0;
        a_drive(2'h0, 300);
        repeat (16000) begin
            @(negedge hclk);
            if (b_oe !== 1'b0) seen = 1'b1;
        end
        `CHK("presence after short low", 1'b0, seen)
        `CHK("grant back to A", 1'b1, grant)
    endtask

    // Open line falls through the pulldown and times out to B
    task automatic t_float;
        @(posedge hclk);
        a_mode <= 2'h2;
        wait_on(2, 1'b1);
        `CHK("grant to B", 1'b0, grant)
        ahb(1'b0, OFS_STATUS, 32'h0);
        `CHK("status B", 1'b1, rd_data[0])
        wait_on(2, 1'b0);
        @(posedge hclk);
        a_mode <= 2'h0;
        wait_on(0, 1'b1);
        `CHK("grant back after A high", 1'b1, grant)
    endtask

    // Traffic on B keeps pass-through alive past the timeout
    task automatic t_pass;
        ahb(1'b1, OFS_CONFIG, 32'h4);
        a_drive(2'h0, 100);
        wait_on(1, 1'b1);
        `CHK("A pulldown in pass", 1'b0, pd_en)
        repeat (4) begin
            repeat (4000) @(posedge hclk);
            b_low <= 1'b1;
            repeat (50) @(posedge hclk);
            b_low <= 1'b0;
        end
        @(negedge hclk);
        `CHK("pass kept by traffic", 1'b1, pass_en)
        ahb(1'b1, OFS_CONFIG, 32'h0);
        wait_on(1, 1'b0);
        wait_on(0, 1'b1);
    endtask

    task automatic t_hv;
        `CHK("charger off", 1'b0, chg_oe)
        a_drive(2'h3, 100);
        wait_on(3, 1'b1);
        wait_on(0, 1'b0);
        repeat (2 * int'(SENSE_TICKS) * 834) @(negedge hclk);
        `CHK("grant to B on high voltage", 1'b0, grant)
        ahb(1'b0, OFS_STATUS, 32'h0);
        `CHK("status high voltage", 3'h5, rd_data[2:0])
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        a_mode = 2'h0; // Controllers idle high through warm-up
        b_low = 1'b0;
        fails = 0;
        checked = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_grant_a();
        t_short();
        t_float();
        t_pass();
        t_hv();
        give_verdict();
    end
endmodule // dual_port_grant_arbiter_bench
